// >>> verilog/cdw_config_word.sv
`timescale 1ns/1ps
// Functional notes
// - bits 41:40 select the drive level of bank 4 and bits 39:38 bank 5.
// - bits 37:36 select the drive level of the feedback output bank.
// - input selects are primary 35:34, secondary 33:32, feedback 31:30.
// - input codes are 00 differential, 01 2.5V, 11 1.8V; 10 is reserved.
// - five-bit divide fields sit at 29:25 down to 4:0, feedback last.
// - memory access time is counted in PLL oscillator ticks.
// - a bank toggles only with its pin low and bit clear, else is disabled.
// - a disabled bank floats when the style pin is low and bit 59 is 0.
// - bit 58 low stops banks high, high stops them low.
// - bits 56 to 52 disable banks 1 to 5 like their active-low pins.
// - divide codes 00000 zero skew, 10000 invert, 10001 /2, 10010 /4.
module cdw_config_word #(
  parameter logic [7:0] NVM_TICKS = cdw_pkg::NVM_ACCESS_TICKS,
  parameter logic FB_STOP_OPPOSITE = cdw_pkg::FB_STOP_OPPOSITE
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic cfg_shift_i,
  input wire logic cfg_bit_i,
  input wire logic cfg_commit_i,
  input wire logic [4:0] bank_output_enable_n_i,
  input wire logic disable_style_select_i,
  input wire logic out_phase_i,
  input wire logic osc_tick_i,
  input wire logic nvm_start_i,
  output logic [9:0] bank_output_pair_o,
  output logic [9:0] bank_output_pair_oe_n_o,
  output logic feedback_output_o,
  output logic feedback_output_oe_n_o,
  output logic [1:0] bank4_drive_o,
  output logic [1:0] bank5_drive_o,
  output logic [1:0] feedback_drive_o,
  output logic [1:0] primary_reference_input_sel_o,
  output logic [1:0] secondary_reference_input_sel_o,
  output logic [1:0] feedback_input_sel_o,
  output logic input_sel_reserved_o,
  output logic pll_disable_o,
  output logic cfg_rejected_o,
  output logic nvm_busy_o,
  output logic nvm_refused_o
);
  localparam int NB = cdw_pkg::NUM_BANKS;

  function automatic logic [4:0] div_field(input logic [59:0] w,
                                           input int b);
    div_field = w[cdw_pkg::DIV_B1_LSB - cdw_pkg::DIV_STEP * b +:
                  cdw_pkg::DIV_W];
  endfunction

  function automatic cdw_pkg::cdw_div_type div_decode(input logic [4:0] c);
    case (c)
      cdw_pkg::DIV_CODE_INV: div_decode = cdw_pkg::DIV_INV;
      cdw_pkg::DIV_CODE_BY2: div_decode = cdw_pkg::DIV_BY2;
      cdw_pkg::DIV_CODE_BY4: div_decode = cdw_pkg::DIV_BY4;
      default: div_decode = cdw_pkg::DIV_ZERO;
    endcase
  endfunction

  logic [59:0] shift_r;
  logic [59:0] shift_nxt;
  logic [5:0] count_r;
  logic [5:0] count_nxt;
  logic [59:0] active_r;
  logic [59:0] active_nxt;
  logic reject_r;
  logic [4:0] en_meta_r;
  logic [4:0] en_sync_r;
  logic style_meta_r;
  logic style_sync_r;
  cdw_pkg::cdw_nvm_type nvm_state_r;
  cdw_pkg::cdw_nvm_type nvm_state_nxt;
  logic [7:0] tick_r;
  logic [7:0] tick_nxt;
  logic refused_r;
  logic word_full_w;
  logic commit_ok_w;
  logic nvm_accept_w;
  logic nvm_refuse_w;
  logic nvm_last_w;
  logic [4:0] en_bits_w;
  logic [NB:0] dis_w;
  logic gated_w;
  logic stop_high_w;

  // shadow word: partial loads never reach the live controls
  assign word_full_w = (count_r == cdw_pkg::CFG_COUNT_FULL);
  assign commit_ok_w = cfg_commit_i & word_full_w;
  assign shift_nxt = (cfg_shift_i && !cfg_commit_i) ?
                     {shift_r[58:0], cfg_bit_i} : shift_r;
  assign count_nxt = cfg_commit_i ? 6'h00 :
                     ((cfg_shift_i && !word_full_w) ? count_r + 6'h01 :
                      count_r);
  assign active_nxt = commit_ok_w ? shift_r : active_r;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      shift_r <= cdw_pkg::CFG_RESET;
      count_r <= 6'h00;
      active_r <= cdw_pkg::CFG_RESET;
      reject_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      count_r <= count_nxt;
      active_r <= active_nxt;
      reject_r <= cfg_commit_i & ~word_full_w;
    end
  end

  // pins are asynchronous to this clock
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      en_meta_r <= 5'h1F;
      en_sync_r <= 5'h1F;
      style_meta_r <= 1'b0;
      style_sync_r <= 1'b0;
    end else begin
      en_meta_r <= bank_output_enable_n_i;
      en_sync_r <= en_meta_r;
      style_meta_r <= disable_style_select_i;
      style_sync_r <= style_meta_r;
    end
  end

  // access length follows the oscillator, so a slow VCO means long access
  assign nvm_last_w = osc_tick_i && (tick_r == NVM_TICKS - 8'h01);
  // a disabled PLL gives no ticks, so such a start would never end
  assign nvm_accept_w = nvm_start_i && nvm_state_r == cdw_pkg::NVM_IDLE &&
                        !active_r[cdw_pkg::PLL_DIS_BIT];
  assign nvm_refuse_w = nvm_start_i & ~nvm_accept_w;

  always_comb begin
    nvm_state_nxt = nvm_state_r;
    tick_nxt = tick_r;
    case (nvm_state_r)
      cdw_pkg::NVM_IDLE: begin
        tick_nxt = 8'h00;
        if (nvm_accept_w) begin
          nvm_state_nxt = cdw_pkg::NVM_BUSY;
        end
      end
      cdw_pkg::NVM_BUSY: begin
        if (nvm_last_w) begin
          nvm_state_nxt = cdw_pkg::NVM_IDLE;
          tick_nxt = 8'h00;
        end else if (osc_tick_i) begin
          tick_nxt = tick_r + 8'h01;
        end
      end
      default: begin
        nvm_state_nxt = cdw_pkg::NVM_IDLE;
        tick_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      nvm_state_r <= cdw_pkg::NVM_IDLE;
      tick_r <= 8'h00;
      refused_r <= 1'b0;
    end else begin
      nvm_state_r <= nvm_state_nxt;
      tick_r <= tick_nxt;
      refused_r <= nvm_refuse_w;
    end
  end

  assign gated_w = style_sync_r | active_r[cdw_pkg::STYLE_BIT];
  assign stop_high_w = ~active_r[cdw_pkg::STOP_LOW_BIT];
  assign dis_w[NB] = 1'b0;

  cdw_bank_if bank_if [NB+1] ();

  for (genvar g = 0; g <= NB; g++) begin : g_bank
    if (g < NB) begin : g_out
      assign en_bits_w[g] = active_r[cdw_pkg::EN_B1_BIT - g];
      assign dis_w[g] = en_sync_r[g] | en_bits_w[g];
      assign bank_if[g].stop_high = stop_high_w;
      assign bank_output_pair_o[2*g+1:2*g] = {2{bank_if[g].q}};
      assign bank_output_pair_oe_n_o[2*g+1:2*g] = {2{bank_if[g].oe_n}};
    end else begin : g_fb
      // opposite-level stop for feedback is a parameter: the text is unclear
      assign bank_if[g].stop_high = FB_STOP_OPPOSITE ? ~stop_high_w :
                                    stop_high_w;
      assign feedback_output_o = bank_if[g].q;
      assign feedback_output_oe_n_o = bank_if[g].oe_n;
    end
    assign bank_if[g].mode = div_decode(div_field(active_r, g));
    assign bank_if[g].disabled = dis_w[g];
    assign bank_if[g].gated = gated_w;
    assign bank_if[g].phase = out_phase_i;
    assign bank_if[g].div_reset = &dis_w[NB-1:0];
    cdw_bank u_bank (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .bif(bank_if[g])
    );
  end

  assign bank4_drive_o = active_r[cdw_pkg::DRV_B4_LSB +: 2];
  assign bank5_drive_o = active_r[cdw_pkg::DRV_B5_LSB +: 2];
  assign feedback_drive_o = active_r[cdw_pkg::DRV_FB_LSB +: 2];
  assign primary_reference_input_sel_o =
    active_r[cdw_pkg::INSEL_PRI_LSB +: 2];
  assign secondary_reference_input_sel_o =
    active_r[cdw_pkg::INSEL_SEC_LSB +: 2];
  assign feedback_input_sel_o =
    active_r[cdw_pkg::INSEL_FB_LSB +: 2];
  assign input_sel_reserved_o =
    (primary_reference_input_sel_o == cdw_pkg::IN_RSVD) ||
    (secondary_reference_input_sel_o == cdw_pkg::IN_RSVD) ||
    (feedback_input_sel_o == cdw_pkg::IN_RSVD);
  assign pll_disable_o = active_r[cdw_pkg::PLL_DIS_BIT];
  assign cfg_rejected_o = reject_r;
  assign nvm_busy_o = (nvm_state_r == cdw_pkg::NVM_BUSY);
  assign nvm_refused_o = refused_r;

  commit_apply_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    cfg_commit_i && count_r == 6'h3C |=> active_r == $past(shift_r))
    else $error("complete word not applied on commit");
  partial_hold_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    cfg_commit_i && count_r != 6'h3C |=> $stable(active_r) && cfg_rejected_o)
    else $error("partial word reached the live controls");
  bank_drive_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    commit_ok_w |=> bank4_drive_o == $past(shift_r[41:40]) &&
                    bank5_drive_o == $past(shift_r[39:38]))
    else $error("bank drive select taken from wrong bits");
  fb_drive_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    commit_ok_w |=> feedback_drive_o == $past(shift_r[37:36]))
    else $error("feedback drive select taken from wrong bits");
  input_sel_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    commit_ok_w |=> primary_reference_input_sel_o == $past(shift_r[35:34])
      && secondary_reference_input_sel_o == $past(shift_r[33:32])
      && feedback_input_sel_o == $past(shift_r[31:30]))
    else $error("input select taken from wrong bits");
  reserved_code_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    commit_ok_w && (shift_r[35:34] == 2'b10 || shift_r[33:32] == 2'b10 ||
                    shift_r[31:30] == 2'b10) |=> input_sel_reserved_o)
    else $error("reserved input code not flagged");
  divide_decode_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    commit_ok_w && shift_r[29:25] == 5'h11 && shift_r[4:0] == 5'h00
    |=> bank_if[0].mode == cdw_pkg::DIV_BY2 &&
        bank_if[NB].mode == cdw_pkg::DIV_ZERO)
    else $error("divide field decoded wrongly");
  enable_bit_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    active_r[56] && !gated_w |=> bank_output_pair_oe_n_o[1:0] == 2'b11)
    else $error("enable bit does not disable bank 1");
  nvm_length_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    nvm_busy_o && osc_tick_i && tick_r == NVM_TICKS - 8'h01 |=> !nvm_busy_o)
    else $error("memory access did not end after its tick count");
  nvm_pll_off_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    nvm_start_i && pll_disable_o |=> nvm_refused_o && $stable(nvm_busy_o))
    else $error("memory access started with the PLL disabled");
endmodule

// >>> verilog/cdw_pkg.sv
package cdw_pkg;
  localparam int CFG_WIDTH = 60;
  localparam logic [5:0] CFG_COUNT_FULL = 6'h3C;
  localparam logic [59:0] CFG_RESET = 60'h0;
  localparam int NUM_BANKS = 5;
  localparam int DRV_B4_LSB = 40;
  localparam int DRV_B5_LSB = 38;
  localparam int DRV_FB_LSB = 36;
  localparam int INSEL_PRI_LSB = 34;
  localparam int INSEL_SEC_LSB = 32;
  localparam int INSEL_FB_LSB = 30;
  localparam int DIV_B1_LSB = 25;
  localparam int DIV_STEP = 5;
  localparam int DIV_W = 5;
  localparam int EN_B1_BIT = 56;
  localparam int PLL_DIS_BIT = 57;
  localparam int STOP_LOW_BIT = 58;
  localparam int STYLE_BIT = 59;
  localparam logic [4:0] DIV_CODE_ZERO = 5'h00;
  localparam logic [4:0] DIV_CODE_INV = 5'h10;
  localparam logic [4:0] DIV_CODE_BY2 = 5'h11;
  localparam logic [4:0] DIV_CODE_BY4 = 5'h12;
  localparam logic [7:0] NVM_ACCESS_TICKS = 8'h40;
  localparam logic FB_STOP_OPPOSITE = 1'b1;

  typedef enum logic [1:0] {
    DIV_ZERO = 2'b00,
    DIV_INV = 2'b01,
    DIV_BY2 = 2'b10,
    DIV_BY4 = 2'b11
  } cdw_div_type;

  typedef enum logic [1:0] {
    IN_DIFF = 2'b00,
    IN_SE25 = 2'b01,
    IN_RSVD = 2'b10,
    IN_SE18 = 2'b11
  } cdw_in_type;

  typedef enum logic {
    NVM_IDLE = 1'b0,
    NVM_BUSY = 1'b1
  } cdw_nvm_type;
endpackage

// >>> verilog/cdw_bank_if.sv
`timescale 1ns/1ps
interface cdw_bank_if;
  cdw_pkg::cdw_div_type mode;
  logic disabled;
  logic gated;
  logic stop_high;
  logic phase;
  logic div_reset;
  logic q;
  logic oe_n;
  modport ctrl (output mode, disabled, gated, stop_high, phase, div_reset,
                input q, oe_n);
  modport bank (input mode, disabled, gated, stop_high, phase, div_reset,
                output q, oe_n);
endinterface

// >>> verilog/cdw_bank.sv
`timescale 1ns/1ps
module cdw_bank (
  input wire logic clock_i,
  input wire logic rst_i,
  cdw_bank_if.bank bif
);
  logic phase_d_r;
  logic [1:0] div_cnt_r;
  logic [1:0] div_cnt_nxt;
  logic q_r;
  logic q_nxt;
  logic oe_n_r;
  logic oe_n_nxt;
  logic rise_w;
  logic src_w;

  assign rise_w = bif.phase & ~phase_d_r;
  // divider restarts from a known state while all five output banks are off (feedback not counted)
  assign div_cnt_nxt = bif.div_reset ? 2'h0 :
                       (rise_w ? div_cnt_r + 2'h1 : div_cnt_r);
  assign src_w = (bif.mode == cdw_pkg::DIV_INV) ? ~bif.phase :
                 (bif.mode == cdw_pkg::DIV_BY2) ? div_cnt_r[0] :
                 (bif.mode == cdw_pkg::DIV_BY4) ? div_cnt_r[1] :
                 bif.phase;
  assign q_nxt = !bif.disabled ? src_w :
                 (bif.gated ? bif.stop_high : q_r);
  assign oe_n_nxt = bif.disabled & ~bif.gated;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      phase_d_r <= 1'b0;
      div_cnt_r <= 2'h0;
      q_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      phase_d_r <= bif.phase;
      div_cnt_r <= div_cnt_nxt;
      q_r <= q_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign bif.q = q_r;
  assign bif.oe_n = oe_n_r;

  gated_level_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    bif.disabled && bif.gated |=> !oe_n_r && q_r == $past(bif.stop_high))
    else $error("gated bank not held at stop level");
  tristate_hold_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    bif.disabled && !bif.gated |=> oe_n_r)
    else $error("disabled bank not released to high impedance");
  normal_toggle_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !bif.disabled && bif.mode == cdw_pkg::DIV_ZERO
    |=> !oe_n_r && q_r == $past(bif.phase))
    else $error("enabled bank does not follow its clock");
  invert_mode_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !bif.disabled && bif.mode == cdw_pkg::DIV_INV
    |=> q_r == !$past(bif.phase))
    else $error("inverted bank does not invert its clock");
endmodule

// >>> dv/cdw_host_model.sv
`timescale 1ns/1ps
module cdw_host_model (
  input wire logic clock_i,
  output logic cfg_shift_o,
  output logic cfg_bit_o,
  output logic cfg_commit_o
);
  initial begin
    cfg_shift_o = 1'b0;
    cfg_bit_o = 1'b1;
    cfg_commit_o = 1'b0;
  end

  // msb first; a count below 60 commits early, which the device must refuse
  task automatic send(input logic [59:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clock_i);
      cfg_shift_o = 1'b1;
      cfg_bit_o = w[59-i];
    end
    @(negedge clock_i);
    cfg_shift_o = 1'b0;
    // data line is not held after the last bit, so show its inverse
    cfg_bit_o = ~cfg_bit_o;
    cfg_commit_o = 1'b1;
    @(negedge clock_i);
    cfg_commit_o = 1'b0;
  endtask
endmodule

// >>> dv/clock_driver_config_word_tb_top.sv
`timescale 1ns/1ps
module clock_driver_config_word_tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] pins_n = 5'h00;
  logic style = 1'b0;
  logic phase = 1'b0;
  logic osc = 1'b0;
  logic nvm_go = 1'b0;
  logic run_ph = 1'b0;
  logic sh, sb, cm, rsvd, pll_dis, rej, busy, refused, fb_o, fb_oe_n;
  logic [9:0] pair, pair_oe_n;
  logic [1:0] b4_drv, b5_drv, fb_drv, pri_sel, sec_sel, fbi_sel;
  logic [59:0] w;
  int n_errors = 0;
  int checks = 0;
  int cnt;
  int codes[6] = '{'h00, 'h10, 'h11, 'h12, 'h03, 'h12};
  int rises[6] = '{32, 32, 16, 8, 32, 8};
  int lsb[6] = '{25, 25, 25, 25, 25, 5};
  int pbit[6] = '{0, 0, 0, 0, 0, 8};
  logic prev;
  logic fprev;
  int fcnt;

  always #5 clock_i = ~clock_i;
  always @(negedge clock_i) if (run_ph) phase <= ~phase;

  cdw_host_model host (.clock_i(clock_i), .cfg_shift_o(sh),
    .cfg_bit_o(sb), .cfg_commit_o(cm));

  cdw_config_word #(.NVM_TICKS(8'h04)) dut (.clock_i(clock_i),
    .rst_i(rst_i), .cfg_shift_i(sh), .cfg_bit_i(sb), .cfg_commit_i(cm),
    .bank_output_enable_n_i(pins_n), .disable_style_select_i(style),
    .out_phase_i(phase), .osc_tick_i(osc), .nvm_start_i(nvm_go),
    .bank_output_pair_o(pair), .bank_output_pair_oe_n_o(pair_oe_n),
    .feedback_output_o(fb_o), .feedback_output_oe_n_o(fb_oe_n),
    .bank4_drive_o(b4_drv), .bank5_drive_o(b5_drv),
    .feedback_drive_o(fb_drv), .primary_reference_input_sel_o(pri_sel),
    .secondary_reference_input_sel_o(sec_sel),
    .feedback_input_sel_o(fbi_sel), .input_sel_reserved_o(rsvd),
    .pll_disable_o(pll_dis), .cfg_rejected_o(rej), .nvm_busy_o(busy),
    .nvm_refused_o(refused));

  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic chk(input string nm, input logic [63:0] exp,
                     input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic pulse_start();
    nvm_go = 1'b1;
    tick(1);
    nvm_go = 1'b0;
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // generous: the whole sequence needs well under 5000 cycles
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end

  initial begin
    tick(10);
    chk("oe_n in reset", 10'h3FF, pair_oe_n);
    rst_i = 1'b0;
    tick(4);
    chk("selects after reset", 12'h000,
        {b4_drv, b5_drv, fb_drv, pri_sel, sec_sel, fbi_sel});
    chk("fb driving", 1'b0, fb_oe_n);
    w = '0;
    w[41:40] = 2'h1;
    w[39:38] = 2'h2;
    w[37:36] = 2'h3;
    w[35:34] = 2'h1;
    w[33:32] = 2'h3;
    host.send(w, 60);
    chk("bank4 drive", 2'h1, b4_drv);
    chk("bank5 drive", 2'h2, b5_drv);
    chk("fb drive", 2'h3, fb_drv);
    chk("in sels", 6'h1C, {pri_sel, sec_sel, fbi_sel});
    chk("reserved flag", 1'b0, rsvd);
    w[33:32] = 2'h2;
    host.send(w, 60);
    chk("reserved flag", 1'b1, rsvd);
    host.send(60'h0, 59);
    chk("reject pulse", 1'b1, rej);
    chk("word kept", 2'h2, sec_sel);
    tick(1);
    chk("reject ends", 1'b0, rej);
    $display("test config map done");

    for (int g = 0; g < 5; g++) begin
      w = '0;
      w[56-g] = 1'b1;
      host.send(w, 60);
      tick(2);
      chk("oe_n by bit", 10'h3 << (2 * g), pair_oe_n);
    end
    w[59] = 1'b1;
    host.send(w, 60);
    tick(2);
    chk("gated oe_n", 10'h000, pair_oe_n);
    chk("stop high", 2'h3, pair[9:8]);
    w[58] = 1'b1;
    host.send(w, 60);
    tick(2);
    chk("stop low", 2'h0, pair[9:8]);
    w = '0;
    w[56] = 1'b1;
    style = 1'b1;
    host.send(w, 60);
    tick(4);
    chk("pin gated", 4'h3, {pair_oe_n[1:0], pair[1:0]});
    style = 1'b0;
    pins_n = 5'h04;
    host.send(60'h0, 60);
    tick(4);
    chk("pin disable", 10'h030, pair_oe_n);
    pins_n = 5'h00;
    $display("test disable done");

    for (int k = 0; k < 6; k++) begin
      w = '0;
      w[lsb[k] +: 5] = codes[k][4:0];
      host.send(w, 60);
      tick(4);
      run_ph = 1'b1;
      cnt = 0;
      fcnt = 0;
      prev = pair[pbit[k]];
      fprev = fb_o;
      repeat (64) begin
        tick(1);
        if (pair[pbit[k]] === 1'b1 && prev === 1'b0) cnt++;
        if (fb_o === 1'b1 && fprev === 1'b0) fcnt++;
        prev = pair[pbit[k]];
        fprev = fb_o;
      end
      run_ph = 1'b0;
      chk("divide edges", 1'b1,
          cnt >= rises[k] - 1 && cnt <= rises[k] + 1);
      chk("fb edges", 1'b1, fcnt >= 31 && fcnt <= 33);
    end
    $display("test divide done");

    host.send(60'h0, 60);
    pulse_start();
    chk("nvm busy", 1'b1, busy);
    // let an edge pass so the start strobe is seen low between requests
    tick(1);
    pulse_start();
    chk("busy refuse", 1'b1, refused);
    osc = 1'b1;
    tick(3);
    chk("busy at 3 ticks", 1'b1, busy);
    tick(1);
    osc = 1'b0;
    chk("busy ends", 1'b0, busy);
    w = '0;
    w[57] = 1'b1;
    host.send(w, 60);
    chk("pll off", 1'b1, pll_dis);
    pulse_start();
    chk("pll off refuse", 2'h1, {busy, refused});
    $display("test memory done");
    end_sim();
  end
endmodule
